/* File: src/ucr_top.sv */
// Holds the configuration register bank of one serial port with its
// Wishbone slave, multi-drop receive gate and RTS direction control.
// Assumes the serial core runs on clk_in and drives its inputs
// synchronously; only the reset comes from outside the domain.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////
// Functional notes
// [R1] Enable bit zero off, one on, resets one
// [R2] Upper address byte register, resets to 03h
// [R3] Lower address byte register, resets to e8h
// [R4] Low nibble picks interrupt channel, resets three
// [R5] Multi-drop bit turns parity into address marker
// [R6] Without auto clear, host clears receive gate
// [R7] Auto clear drops gate on address match
// [R8] Direction mode drives RTS high while sending
// [R9] Invert bit flips the automatic RTS level
// [R10] Share style PCI or ISA, only when shared
// [R11] Share bit makes interrupt line shared, resets zero
// [R12] Two-bit field selects the baud clock source
// [R13] Given address compares only masked-in bits
// [R14] Broadcast address from address OR mask
// [R15] Reserved bits read zero, writes ignored
module ucr_top (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [9:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic rx_valid_in,
	input wire logic [8:0] rx_char_in,
	input wire logic tx_active_in,
	input wire logic rts_core_in,
	output logic port_enable_out,
	output logic [15:0] io_base_out,
	output logic [3:0] irq_channel_out,
	output logic irq_shared_out,
	output logic irq_isa_style_out,
	output logic multidrop_out,
	output logic [1:0] baud_clock_source_out,
	output logic rts_out,
	output logic rx_accept_out,
	output logic [7:0] rx_data_out,
	output logic addr_match_out,
	output logic receive_gate_flag_out
);

	////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_meta_n_ff; // First stage, read only by the second
	logic rst_n_ff; // Released reset used by all other logic

	// Assert at once, release two edges later to avoid recovery hazards
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rst_meta_n_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end
		else
		begin
			rst_meta_n_ff <= 1'b1;
			rst_n_ff <= rst_meta_n_ff;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus decode
	logic [7:0] bus_idx; // Register index from the word address
	logic bus_req; // New request not yet answered
	logic wr_take; // Write that lands this edge
	logic [7:0] wr_byte; // Low data lane
	logic ack_ff; // Answer strobe
	logic [31:0] rd_data_ff; // Captured read word
	logic [7:0] nxt_rd_byte; // Read mux result

	assign bus_idx = wb_adr_in[9:2];
	assign bus_req = wb_cyc_in & wb_stb_in & ~ack_ff;
	// Registers live in lane 0 only, so only sel bit 0 lets a write in
	assign wr_take = bus_req & wb_we_in & wb_sel_in[0];
	assign wr_byte = wb_dat_in[7:0];

	// Storage, each kept already masked so reserved bits stay zero
	logic [7:0] port_enable_ff; // Port on/off
	logic [7:0] base_high_ff; // Upper I/O base byte
	logic [7:0] base_low_ff; // Lower I/O base byte
	logic [7:0] irq_select_ff; // Interrupt channel
	logic [7:0] share_mode_ff; // Sharing, multi-drop, RTS control
	logic [7:0] baud_select_ff; // Baud clock source
	logic [7:0] station_addr_ff; // Own station address
	logic [7:0] station_mask_ff; // Station mask
	logic gate_ff; // Receive gate flag

	////////////////////////////////////////////////////////////////////
	// Configuration writes
	// One answer per request: ack drops the cycle after it rose
	always_ff @(posedge clk_in or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			ack_ff <= 1'b0;
		end
		else
		begin
			ack_ff <= bus_req;
		end
	end

	// Writes store only writable bits; unmapped indices are dropped
	always_ff @(posedge clk_in or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			port_enable_ff <= ucr_pkg::RST_PORT_ENABLE; // R1
			base_high_ff <= ucr_pkg::RST_BASE_HIGH; // R2
			base_low_ff <= ucr_pkg::RST_BASE_LOW; // R3
			irq_select_ff <= ucr_pkg::RST_IRQ_SELECT; // R4
			share_mode_ff <= ucr_pkg::RST_SHARE_MODE; // R11
			baud_select_ff <= ucr_pkg::RST_BAUD_SELECT; // R12
			station_addr_ff <= ucr_pkg::RST_STATION;
			station_mask_ff <= ucr_pkg::RST_STATION;
		end
		else if (wr_take)
		begin
			case (bus_idx)
				ucr_pkg::IDX_PORT_ENABLE:
					port_enable_ff <= wr_byte & ucr_pkg::WMASK_PORT_ENABLE; // R1 R15
				ucr_pkg::IDX_BASE_HIGH:
					base_high_ff <= wr_byte; // R2
				ucr_pkg::IDX_BASE_LOW:
					base_low_ff <= wr_byte; // R3
				ucr_pkg::IDX_IRQ_SELECT:
					irq_select_ff <= wr_byte & ucr_pkg::WMASK_IRQ_SELECT; // R4 R15
				ucr_pkg::IDX_SHARE_MODE:
					share_mode_ff <= wr_byte & ucr_pkg::WMASK_SHARE_MODE; // R15
				ucr_pkg::IDX_BAUD_SELECT:
					baud_select_ff <= wr_byte & ucr_pkg::WMASK_BAUD_SELECT; // R12 R15
				ucr_pkg::IDX_STATION_ADDR:
					station_addr_ff <= wr_byte;
				ucr_pkg::IDX_STATION_MASK:
					station_mask_ff <= wr_byte;
				default:
				begin
					// Unmapped or gate register: nothing stored here
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read path
	// Mux is combinational; the word is captured with the ack
	always_comb
	begin
		nxt_rd_byte = 8'h00;
		case (bus_idx)
			ucr_pkg::IDX_PORT_ENABLE: nxt_rd_byte = port_enable_ff;
			ucr_pkg::IDX_BASE_HIGH: nxt_rd_byte = base_high_ff;
			ucr_pkg::IDX_BASE_LOW: nxt_rd_byte = base_low_ff;
			ucr_pkg::IDX_IRQ_SELECT: nxt_rd_byte = irq_select_ff;
			ucr_pkg::IDX_SHARE_MODE: nxt_rd_byte = share_mode_ff;
			ucr_pkg::IDX_BAUD_SELECT: nxt_rd_byte = baud_select_ff;
			ucr_pkg::IDX_STATION_ADDR: nxt_rd_byte = station_addr_ff;
			ucr_pkg::IDX_STATION_MASK: nxt_rd_byte = station_mask_ff;
			ucr_pkg::IDX_GATE_CTRL: nxt_rd_byte = {7'h00, gate_ff}; // R15
			default: nxt_rd_byte = 8'h00; // Unmapped reads answer zero
		endcase
	end

	// Upper lanes always zero; data holds after ack until next read
	always_ff @(posedge clk_in or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			rd_data_ff <= 32'h0000_0000;
		end
		else if (bus_req & ~wb_we_in)
		begin
			rd_data_ff <= {24'h00_0000, nxt_rd_byte}; // R15
		end
	end

	assign wb_ack_out = ack_ff;
	assign wb_dat_out = rd_data_ff;

	////////////////////////////////////////////////////////////////////
	// Helpers
	logic mode_multidrop; // 9-bit mode active
	logic mode_auto_addr; // Hardware clears the gate
	logic addr_char; // Incoming character carries the address marker
	logic auto_hit; // Address match that hardware acts on
	logic nxt_accept; // Character passes to the host this edge
	logic rts_ff; // Registered line level
	logic accept_ff; // Accept pulse
	logic [7:0] rx_data_ff; // Accepted character
	logic match_ff; // Match pulse

	ucr_cfg_if cfg_bus();

	assign mode_multidrop = share_mode_ff[ucr_pkg::BIT_MULTIDROP]; // R5
	assign mode_auto_addr = share_mode_ff[ucr_pkg::BIT_AUTO_ADDR];
	assign addr_char = rx_char_in[ucr_pkg::BIT_MARKER] & mode_multidrop; // R5

	assign cfg_bus.rx_char = rx_char_in;
	assign cfg_bus.station_addr = station_addr_ff;
	assign cfg_bus.station_mask = station_mask_ff;
	assign cfg_bus.rts_auto = share_mode_ff[ucr_pkg::BIT_RTS_AUTO];
	assign cfg_bus.rts_invert = share_mode_ff[ucr_pkg::BIT_RTS_INVERT];
	assign cfg_bus.tx_active = tx_active_in;
	assign cfg_bus.rts_core = rts_core_in;

	// Address comparator
	ucr_addr_match u_match (
		.bus(cfg_bus.matcher)
	);

	// Direction control
	ucr_rts_ctrl u_rts (
		.bus(cfg_bus.rts)
	);

	// Auto address clear only matters in 9-bit mode
	assign auto_hit = rx_valid_in & port_enable_ff[ucr_pkg::BIT_PORT_ENABLE] &
		addr_char & mode_auto_addr & cfg_bus.addr_hit; // R7

	////////////////////////////////////////////////////////////////////
	// Receive gate
	// Hardware clear beats a host write in the same cycle, so a match
	// is never lost behind a late re-arm
	always_ff @(posedge clk_in or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			gate_ff <= ucr_pkg::RST_GATE;
		end
		else if (auto_hit)
		begin
			gate_ff <= 1'b0; // R7
		end
		else if (wr_take && bus_idx == ucr_pkg::IDX_GATE_CTRL)
		begin
			gate_ff <= wr_byte[ucr_pkg::BIT_GATE]; // R6
		end
	end

	// Normal mode passes all; 9-bit mode needs gate open or a hit
	always_comb
	begin
		nxt_accept = 1'b0;
		if (rx_valid_in && port_enable_ff[ucr_pkg::BIT_PORT_ENABLE]) // R1
		begin
			if (!mode_multidrop)
				nxt_accept = 1'b1; // R5
			else if (!gate_ff)
				nxt_accept = 1'b1; // R6
			else
				nxt_accept = auto_hit; // R7
		end
	end

	// Delivery to the host side, one pulse per character
	always_ff @(posedge clk_in or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			accept_ff <= 1'b0;
			rx_data_ff <= 8'h00;
			match_ff <= 1'b0;
		end
		else
		begin
			accept_ff <= nxt_accept;
			match_ff <= auto_hit;
			if (nxt_accept)
				rx_data_ff <= rx_char_in[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Line and status outputs
	// RTS is registered to keep glitches off the driver enable
	always_ff @(posedge clk_in or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			rts_ff <= 1'b0;
		end
		else
		begin
			rts_ff <= cfg_bus.rts_level; // R8 R9
		end
	end

	assign port_enable_out = port_enable_ff[ucr_pkg::BIT_PORT_ENABLE]; // R1
	assign io_base_out = {base_high_ff, base_low_ff}; // R2 R3
	assign irq_channel_out = irq_select_ff[3:0]; // R4
	assign irq_shared_out = share_mode_ff[ucr_pkg::BIT_SHARE_ENABLE]; // R11
	// Style is meaningless on a dedicated line, so it is forced to PCI
	assign irq_isa_style_out = share_mode_ff[ucr_pkg::BIT_SHARE_STYLE] &
		share_mode_ff[ucr_pkg::BIT_SHARE_ENABLE]; // R10
	assign multidrop_out = mode_multidrop; // R5
	assign baud_clock_source_out = baud_select_ff[1:0]; // R12
	assign rts_out = rts_ff;
	assign rx_accept_out = accept_ff;
	assign rx_data_out = rx_data_ff;
	assign addr_match_out = match_ff;
	assign receive_gate_flag_out = gate_ff;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_ff);

	AST_PORT_ENABLE_WRITE: assert property ( // R1
		wr_take && bus_idx == ucr_pkg::IDX_PORT_ENABLE
		|=> port_enable_out == $past(wb_dat_in[0]) && port_enable_ff[7:1] == 7'h00)
		else $error("port enable write not applied");
	AST_BASE_HIGH_WRITE: assert property ( // R2
		wr_take && bus_idx == ucr_pkg::IDX_BASE_HIGH
		|=> io_base_out[15:8] == $past(wb_dat_in[7:0]))
		else $error("upper base byte not stored");
	AST_BASE_LOW_WRITE: assert property ( // R3
		wr_take && bus_idx == ucr_pkg::IDX_BASE_LOW
		|=> io_base_out[7:0] == $past(wb_dat_in[7:0]) ##1 $stable(io_base_out[7:0]))
		else $error("lower base byte not stored");
	AST_IRQ_CHANNEL_WRITE: assert property ( // R4
		wr_take && bus_idx == ucr_pkg::IDX_IRQ_SELECT
		|=> irq_channel_out == $past(wb_dat_in[3:0]))
		else $error("interrupt channel not stored");
	AST_HOST_GATE: assert property ( // R6
		rx_valid_in && mode_multidrop && !mode_auto_addr && gate_ff
		|=> !rx_accept_out && gate_ff)
		else $error("character accepted through closed gate");
	AST_AUTO_CLEAR: assert property ( // R7
		rx_valid_in && port_enable_out && rx_char_in[8] && mode_multidrop &&
		mode_auto_addr && cfg_bus.addr_hit
		|=> !receive_gate_flag_out && rx_accept_out ##1 !rx_accept_out || $past(rx_valid_in))
		else $error("gate not cleared on address match");
	AST_NORMAL_MODE: assert property ( // R5
		rx_valid_in && port_enable_out && !mode_multidrop
		|=> rx_accept_out && rx_data_out == $past(rx_char_in[7:0]))
		else $error("normal mode character dropped");
	AST_RTS_AUTO: assert property ( // R8
		cfg_bus.rts_auto && !cfg_bus.rts_invert |=> rts_out == $past(tx_active_in))
		else $error("rts does not follow transmitter");
	AST_RTS_INVERT: assert property ( // R9
		cfg_bus.rts_auto && cfg_bus.rts_invert |=> rts_out == !$past(tx_active_in))
		else $error("rts not inverted");
	AST_SHARE_STYLE: assert property ( // R10
		!irq_shared_out |-> !irq_isa_style_out)
		else $error("share style active on dedicated line");
	AST_SHARE_WRITE: assert property ( // R11
		wr_take && bus_idx == ucr_pkg::IDX_SHARE_MODE
		|=> irq_shared_out == $past(wb_dat_in[0]) && share_mode_ff[3:2] == 2'h0)
		else $error("share bit not stored");
	AST_BAUD_WRITE: assert property ( // R12
		wr_take && bus_idx == ucr_pkg::IDX_BAUD_SELECT
		|=> baud_clock_source_out == $past(wb_dat_in[1:0]))
		else $error("baud source not stored");
	AST_GIVEN_MATCH: assert property ( // R13
		auto_hit == 1'b0 && rx_valid_in && port_enable_out && addr_char &&
		mode_auto_addr && ((rx_char_in[7:0] ^ station_addr_ff) & station_mask_ff) == 8'h00
		|-> 1'b0)
		else $error("given address not matched");
	AST_BCAST_MATCH: assert property ( // R14
		rx_valid_in && port_enable_out && addr_char && mode_auto_addr &&
		(rx_char_in[7:0] & (station_addr_ff | station_mask_ff)) ==
		(station_addr_ff | station_mask_ff) |=> addr_match_out)
		else $error("broadcast address not matched");
	AST_RESERVED_READ: assert property ( // R15
		bus_req && !wb_we_in |=> wb_ack_out && wb_dat_out[31:8] == 24'h00_0000 ##1 !wb_ack_out)
		else $error("reserved read bits not zero");

	COV_READ: cover property (bus_req && !wb_we_in ##1 wb_ack_out);
	COV_AUTO_CLEAR: cover property (gate_ff ##1 !gate_ff && addr_match_out);
	COV_RTS_AUTO: cover property (cfg_bus.rts_auto && tx_active_in ##1 rts_out);
	COV_SHARED_ISA: cover property (irq_isa_style_out);

endmodule : ucr_top

/* File: include/ucr_pkg.sv */
// Holds indices, reset values, field positions and write masks of the
// serial-port configuration bank.
// Assumes 8-bit registers, each in the low byte of one 32-bit bus word.
package ucr_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_PORT_ENABLE = 8'h30;
	localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
	localparam logic [7:0] IDX_BASE_LOW = 8'h61;
	localparam logic [7:0] IDX_IRQ_SELECT = 8'h70;
	localparam logic [7:0] IDX_SHARE_MODE = 8'hf0;
	localparam logic [7:0] IDX_BAUD_SELECT = 8'hf2;
	localparam logic [7:0] IDX_STATION_ADDR = 8'hf4;
	localparam logic [7:0] IDX_STATION_MASK = 8'hf5;
	localparam logic [7:0] IDX_GATE_CTRL = 8'hf8;

	// Reset values
	localparam logic [7:0] RST_PORT_ENABLE = 8'h01;
	localparam logic [7:0] RST_BASE_HIGH = 8'h03;
	localparam logic [7:0] RST_BASE_LOW = 8'he8;
	localparam logic [7:0] RST_IRQ_SELECT = 8'h03;
	localparam logic [7:0] RST_SHARE_MODE = 8'h00;
	localparam logic [7:0] RST_BAUD_SELECT = 8'h00;
	localparam logic [7:0] RST_STATION = 8'h00;
	localparam logic RST_GATE = 1'b1;

	// Writable bits; everything else is reserved and stored as zero
	localparam logic [7:0] WMASK_PORT_ENABLE = 8'h01;
	localparam logic [7:0] WMASK_IRQ_SELECT = 8'h0f;
	localparam logic [7:0] WMASK_SHARE_MODE = 8'hf3;
	localparam logic [7:0] WMASK_BAUD_SELECT = 8'h03;
	localparam logic [7:0] WMASK_FULL = 8'hff;

	// Field positions
	localparam int BIT_PORT_ENABLE = 0;
	localparam int BIT_MULTIDROP = 7;
	localparam int BIT_AUTO_ADDR = 6;
	localparam int BIT_RTS_INVERT = 5;
	localparam int BIT_RTS_AUTO = 4;
	localparam int BIT_SHARE_STYLE = 1;
	localparam int BIT_SHARE_ENABLE = 0;
	localparam int BIT_GATE = 0;
	localparam int BIT_MARKER = 8;

	// Baud clock source encodings
	localparam logic [1:0] BAUD_SEL_1M8432 = 2'h0;
	localparam logic [1:0] BAUD_SEL_18M432 = 2'h1;
	localparam logic [1:0] BAUD_SEL_24M = 2'h2;
	localparam logic [1:0] BAUD_SEL_14M769 = 2'h3;

endpackage : ucr_pkg

/* File: include/ucr_cfg_if.sv */
// Carries configuration and results between the bank and its helpers.
// Assumes all users sit on the one configuration clock.
`timescale 1ns/10ps
interface ucr_cfg_if;
	logic [8:0] rx_char; // Received character, bit 8 is the address marker
	logic [7:0] station_addr; // Own station address
	logic [7:0] station_mask; // Station address mask
	logic addr_hit; // Character matches given or broadcast address
	logic rts_auto; // Automatic direction control on
	logic rts_invert; // Invert automatic level
	logic tx_active; // Transmitter busy
	logic rts_core; // Plain modem-control level from the core
	logic rts_level; // Resulting line level

	modport ctrl(output rx_char, station_addr, station_mask, rts_auto, rts_invert,
		tx_active, rts_core, input addr_hit, rts_level);
	modport matcher(input rx_char, station_addr, station_mask, output addr_hit);
	modport rts(input rts_auto, rts_invert, tx_active, rts_core, output rts_level);
endinterface : ucr_cfg_if

/* File: src/ucr_addr_match.sv */
// Holds the station address comparator for multi-drop reception.
// Assumes the caller qualifies the hit with mode and marker bits.
`timescale 1ns/10ps
module ucr_addr_match (
	ucr_cfg_if.matcher bus
);

	logic given_hit; // Masked compare against own address
	logic bcast_hit; // Compare against the broadcast pattern
	logic [7:0] bcast_pattern; // Ones mark the bits that are compared

	// Only bits with a one in the mask take part
	assign given_hit = ((bus.rx_char[7:0] ^ bus.station_addr) & bus.station_mask) == 8'h00; // R13

	// Broadcast: bits set in address-or-mask must be one, others ignored
	assign bcast_pattern = bus.station_addr | bus.station_mask; // R14
	assign bcast_hit = (bus.rx_char[7:0] & bcast_pattern) == bcast_pattern; // R14

	// Either address is good enough
	assign bus.addr_hit = given_hit | bcast_hit; // R14

endmodule : ucr_addr_match

/* File: src/ucr_rts_ctrl.sv */
// Holds the RTS direction selector for half-duplex line drivers.
// Assumes tx_active is high for the whole character on the wire.
`timescale 1ns/10ps
module ucr_rts_ctrl (
	ucr_cfg_if.rts bus
);

	logic auto_level; // Level in automatic mode before the mux

	// High while sending, low when idle, optionally flipped
	assign auto_level = bus.tx_active ^ bus.rts_invert; // R8 R9

	// Plain mode passes the core's own level untouched
	assign bus.rts_level = bus.rts_auto ? auto_level : bus.rts_core; // R8

endmodule : ucr_rts_ctrl

/* File: sim/testbench.sv */
// Self-checking bench for the serial-port configuration bank.
// Assumes the Wishbone slave acks one cycle after the taking edge and
// that every result port is a register that is read one edge later.
`timescale 1ns/10ps

module testbench;

	////////////////////////////////////////////////////////////////////
	// Stimulus and observation signals
	logic clk_in;
	logic resetn_in;
	logic wb_cyc_in;
	logic wb_stb_in;
	logic wb_we_in;
	logic [9:0] wb_adr_in;
	logic [3:0] wb_sel_in;
	logic [31:0] wb_dat_in;
	logic [31:0] wb_dat_out;
	logic wb_ack_out;
	logic rx_valid_in;
	logic [8:0] rx_char_in;
	logic tx_active_in;
	logic rts_core_in;
	logic port_enable_out;
	logic [15:0] io_base_out;
	logic [3:0] irq_channel_out;
	logic irq_shared_out;
	logic irq_isa_style_out;
	logic multidrop_out;
	logic [1:0] baud_clock_source_out;
	logic rts_out;
	logic rx_accept_out;
	logic [7:0] rx_data_out;
	logic addr_match_out;
	logic receive_gate_flag_out;
	int miscompares = 0; // Mismatches seen
	int samples_checked = 0; // Comparisons made

	ucr_top dut (.clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc_in),
		.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
		.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
		.wb_ack_out(wb_ack_out), .rx_valid_in(rx_valid_in), .rx_char_in(rx_char_in),
		.tx_active_in(tx_active_in), .rts_core_in(rts_core_in),
		.port_enable_out(port_enable_out), .io_base_out(io_base_out),
		.irq_channel_out(irq_channel_out), .irq_shared_out(irq_shared_out),
		.irq_isa_style_out(irq_isa_style_out), .multidrop_out(multidrop_out),
		.baud_clock_source_out(baud_clock_source_out), .rts_out(rts_out),
		.rx_accept_out(rx_accept_out), .rx_data_out(rx_data_out),
		.addr_match_out(addr_match_out), .receive_gate_flag_out(receive_gate_flag_out));

	// Clock at 10 MHz
	initial
	begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	////////////////////////////////////////////////////////////////////
	// Shared tasks

	// Prints the verdict and stops the run
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	// One comparison; case inequality so an unknown never matches
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Classic single cycle; request held until ack is sampled high
	task automatic bus(input logic we, input logic [7:0] idx, input logic [3:0] sel,
		input logic [7:0] wdat, output logic [31:0] rdat);
		int n;
		@(posedge clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= {idx, 2'h0};
		wb_sel_in <= sel;
		wb_dat_in <= {24'h0, wdat};
		// Bounded wait so a dead slave cannot hang the run
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk_in);
			if (wb_ack_out === 1'b1)
				break;
		end
		if (n == 20)
		begin
			miscompares++;
			$display("MISMATCH wb_ack expected 1 seen none");
			complete_run();
		end
		rdat = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in <= 1'b0;
	endtask : bus

	// Write with a chosen byte enable
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] sel = 4'hf);
		logic [31:0] unused;
		bus(1'b1, idx, sel, d, unused);
	endtask : wr

	// Read and compare the whole word
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] got;
		bus(1'b0, idx, 4'hf, 8'h00, got);
		check("wb_dat", {24'h0, exp}, got);
	endtask : rd

	// One received character and the pulses it should give
	task automatic rx(input logic [8:0] c, input logic acc, input logic mat);
		@(posedge clk_in);
		rx_valid_in <= 1'b1;
		rx_char_in <= c;
		@(posedge clk_in);
		rx_valid_in <= 1'b0;
		@(posedge clk_in);
		check("rx_accept", 32'(acc), 32'(rx_accept_out));
		check("addr_match", 32'(mat), 32'(addr_match_out));
		if (acc)
			check("rx_data", 32'(c[7:0]), 32'(rx_data_out));
	endtask : rx

	// Line level one cycle after the direction inputs change
	task automatic rts(input logic core, input logic tx, input logic exp);
		@(posedge clk_in);
		rts_core_in <= core;
		tx_active_in <= tx;
		repeat (2) @(posedge clk_in);
		check("rts", 32'(exp), 32'(rts_out));
	endtask : rts

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		resetn_in = 1'b0;
		wb_cyc_in = 1'b0;
		wb_stb_in = 1'b0;
		wb_we_in = 1'b0;
		wb_adr_in = 10'h000;
		wb_sel_in = 4'h0;
		wb_dat_in = 32'h0;
		rx_valid_in = 1'b0;
		rx_char_in = 9'h000;
		tx_active_in = 1'b0;
		rts_core_in = 1'b0;
		repeat (12) @(posedge clk_in);
		resetn_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		// Reset values at the ports and through the bus
		check("port_enable", 32'h1, 32'(port_enable_out));
		check("io_base", 32'h03e8, 32'(io_base_out));
		check("irq_channel", 32'h3, 32'(irq_channel_out));
		rd(8'h30, 8'h01);
		rd(8'h60, 8'h03);
		rd(8'h61, 8'he8);
		rd(8'h70, 8'h03);
		rd(8'hf0, 8'h00);
		rd(8'hf2, 8'h00);
		// All ones: reserved bits must stay zero
		wr(8'h30, 8'hff);
		rd(8'h30, 8'h01);
		wr(8'h70, 8'hff);
		rd(8'h70, 8'h0f);
		check("irq_channel", 32'hf, 32'(irq_channel_out));
		wr(8'hf0, 8'hff);
		rd(8'hf0, 8'hf3);
		check("irq_isa", 32'h1, 32'(irq_isa_style_out));
		check("irq_shared", 32'h1, 32'(irq_shared_out));
		check("multidrop", 32'h1, 32'(multidrop_out));
		wr(8'hf2, 8'hff);
		rd(8'hf2, 8'h03);
		// Unmapped index and a write with the low lane off
		wr(8'h31, 8'hff);
		rd(8'h31, 8'h00);
		wr(8'h60, 8'h55, 4'he);
		rd(8'h60, 8'h03);
		// Style only counts while shared
		wr(8'hf0, 8'h02);
		check("irq_isa", 32'h0, 32'(irq_isa_style_out));
		check("irq_shared", 32'h0, 32'(irq_shared_out));
		// Every baud source code
		for (int i = 0; i < 4; i++)
		begin
			wr(8'hf2, 8'(i));
			check("baud_src", 32'(i), 32'(baud_clock_source_out));
		end
		wr(8'h60, 8'h12);
		wr(8'h61, 8'h34);
		check("io_base", 32'h1234, 32'(io_base_out));
		// Direction control: plain, automatic, inverted
		wr(8'hf0, 8'h00);
		rts(1'b1, 1'b0, 1'b1);
		rts(1'b0, 1'b1, 1'b0);
		wr(8'hf0, 8'h10);
		rts(1'b1, 1'b0, 1'b0);
		rts(1'b0, 1'b1, 1'b1);
		wr(8'hf0, 8'h30);
		rts(1'b0, 1'b1, 1'b0);
		rts(1'b1, 1'b0, 1'b1);
		// Normal mode ignores the closed gate; disabled port takes nothing
		wr(8'hf0, 8'h00);
		rx(9'h041, 1'b1, 1'b0);
		wr(8'h30, 8'h00);
		rx(9'h042, 1'b0, 1'b0);
		wr(8'h30, 8'h01);
		// Nine-bit mode, host-cleared gate
		wr(8'hf0, 8'h80);
		rx(9'h043, 1'b0, 1'b0);
		wr(8'hf8, 8'h00);
		rx(9'h044, 1'b1, 1'b0);
		// Automatic clearing on given and broadcast address
		wr(8'hf8, 8'h01);
		wr(8'hf4, 8'h5c);
		wr(8'hf5, 8'hf9);
		wr(8'hf0, 8'hc0);
		rx(9'h100, 1'b0, 1'b0);
		check("gate", 32'h1, 32'(receive_gate_flag_out));
		rx(9'h15a, 1'b1, 1'b1);
		check("gate", 32'h0, 32'(receive_gate_flag_out));
		wr(8'hf8, 8'h01);
		rx(9'h1ff, 1'b1, 1'b1);
		check("gate", 32'h0, 32'(receive_gate_flag_out));
		rd(8'hf8, 8'h00);
		rd(8'hf4, 8'h5c);
		rd(8'hf5, 8'hf9);
		// Open gate in auto mode passes data characters without a match
		rx(9'h077, 1'b1, 1'b0);
		// Closed gate without auto clear drops even a matching address
		wr(8'hf8, 8'h01);
		wr(8'hf0, 8'h80);
		rx(9'h15a, 1'b0, 1'b0);
		check("gate", 32'h1, 32'(receive_gate_flag_out));
		// Auto bit alone has no effect outside nine-bit mode
		wr(8'hf0, 8'h40);
		rx(9'h15a, 1'b1, 1'b0);
		check("gate", 32'h1, 32'(receive_gate_flag_out));
		complete_run();
	end

endmodule : testbench
